/* File: rtl/external_memory_interface.sv */
`timescale 1ns/1ps
module external_memory_interface (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  // special function register port
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic      [7:0]  sfr_rdata_out,
  // core move request
  input  wire logic        move_req_in,
  input  wire logic        move_wide_in,
  input  wire logic        move_write_in,
  input  wire logic [7:0]  index_reg_in,
  input  wire logic [15:0] data_pointer_in,
  input  wire logic [7:0]  move_wdata_in,
  output logic             move_busy_out,
  output logic             move_done_out,
  output logic      [7:0]  move_rdata_out,
  // on-chip data ram
  output logic             onchip_req_out,
  output logic             onchip_we_out,
  output logic      [9:0]  onchip_addr_out,
  output logic      [7:0]  onchip_wdata_out,
  input  wire logic [7:0]  onchip_rdata_in,
  // external memory pins
  input  wire logic [7:0]  ad_pins_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe_n_out,
  output logic      [7:0]  addr_lo_out,
  output logic             addr_lo_oe_n_out,
  output logic      [7:0]  addr_hi_out,
  output logic             addr_hi_oe_n_out,
  output logic             ale_out,
  output logic             rd_n_out,
  output logic             wr_n_out
);

  typedef struct packed {
    emi_pkg::emi_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  timing;
    logic [4:0]  cfg;
    logic [7:0]  page;
    logic [15:0] ea;
    logic        write;
    logic        mux;
    logic        hi_drv;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  sfr_rdata;
    logic        busy;
    logic        done;
    logic        on_req;
    logic        on_we;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        mark1;
    logic        mark2;
    logic [7:0]  ad;
    logic        ad_oe_n;
    logic        lo_oe_n;
    logic        hi_oe_n;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
  } emi_regs_t;

  localparam emi_regs_t REGS_RST = '{
    st: emi_pkg::ST_IDLE, cnt: 4'h0, timing: emi_pkg::TIMING_RST,
    cfg: emi_pkg::CONFIG_RST, page: emi_pkg::PAGE_RST, ea: 16'h0000,
    write: 1'b0, mux: 1'b0, hi_drv: 1'b0, wdata: 8'h00, rdata: 8'h00,
    sfr_rdata: 8'h00, busy: 1'b0, done: 1'b0, on_req: 1'b0, on_we: 1'b0,
    sync1: 8'h00, sync2: 8'h00, mark1: 1'b0, mark2: 1'b0, ad: 8'h00,
    ad_oe_n: 1'b1, lo_oe_n: 1'b1, hi_oe_n: 1'b1, ale: 1'b0,
    rd_n: 1'b1, wr_n: 1'b1};

  emi_regs_t r;
  emi_regs_t r_nxt;

  logic [1:0]  setup_f;
  logic [3:0]  strobe_f;
  logic [1:0]  hold_f;
  logic [1:0]  latch_f;
  logic [1:0]  mode_f;
  logic [15:0] req_ea;
  logic        req_onchip;

  assign setup_f  = r.timing[emi_pkg::SETUP_LSB +: 2];
  assign strobe_f = r.timing[emi_pkg::STROBE_LSB +: 4];
  assign hold_f   = r.timing[emi_pkg::HOLD_LSB +: 2];
  assign latch_f  = r.cfg[emi_pkg::LATCH_LSB +: 2];
  assign mode_f   = r.cfg[emi_pkg::MODE_LSB +: 2];

  // effective address and on-chip decision
  assign req_ea = move_wide_in ? data_pointer_in : {r.page, index_reg_in};
  assign req_onchip = (mode_f == emi_pkg::MODE_INTERNAL) ||
                      ((mode_f != emi_pkg::MODE_EXTERNAL) &&
                       (req_ea < emi_pkg::ONCHIP_SIZE));

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic addr_phase;
    logic drive;
    addr_phase = 1'b0;
    drive = 1'b0;
    r_nxt = r;
    r_nxt.done = 1'b0;
    r_nxt.on_req = 1'b0;
    r_nxt.mark1 = 1'b0;
    r_nxt.mark2 = r.mark1;
    r_nxt.sync1 = ad_pins_in;
    r_nxt.sync2 = r.sync1;
    // read data sampled at the strobe end, seen through the synchroniser
    if (r.mark2)
    begin
      r_nxt.rdata = r.sync2;
    end

    // register port
    if (sfr_wr_in)
    begin
      case (sfr_addr_in)
        emi_pkg::TIMING_ADDR: r_nxt.timing = sfr_wdata_in;
        emi_pkg::CONFIG_ADDR: r_nxt.cfg = sfr_wdata_in[4:0];
        emi_pkg::PAGE_ADDR:   r_nxt.page = sfr_wdata_in;
        default:              r_nxt.page = r.page;
      endcase
    end
    if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        emi_pkg::TIMING_ADDR: r_nxt.sfr_rdata = r.timing;
        emi_pkg::CONFIG_ADDR: r_nxt.sfr_rdata = {3'h0, r.cfg};
        emi_pkg::PAGE_ADDR:   r_nxt.sfr_rdata = r.page;
        default:              r_nxt.sfr_rdata = 8'h00;
      endcase
    end

    // access sequencer
    case (r.st)
      emi_pkg::ST_IDLE:
      begin
        if (move_req_in)
        begin
          r_nxt.busy = 1'b1;
          r_nxt.write = move_write_in;
          r_nxt.wdata = move_wdata_in;
          r_nxt.ea = req_ea;
          r_nxt.mux = ~r.cfg[emi_pkg::MUX_BIT];
          r_nxt.hi_drv = move_wide_in || (mode_f == emi_pkg::MODE_BANK);
          if (req_onchip)
          begin
            r_nxt.st = emi_pkg::ST_ONCHIP;
            r_nxt.cnt = 4'h1;
            r_nxt.on_req = 1'b1;
            r_nxt.on_we = move_write_in;
          end
          else
          begin
            r_nxt.st = emi_pkg::ST_LEAD;
            r_nxt.cnt = 4'h0;
          end
        end
      end
      emi_pkg::ST_ONCHIP:
      begin
        r_nxt.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0)
        begin
          r_nxt.rdata = onchip_rdata_in;
          r_nxt.st = emi_pkg::ST_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end
      end
      emi_pkg::ST_LEAD, emi_pkg::ST_ALE_HI, emi_pkg::ST_ALE_LO, emi_pkg::ST_SETUP:
      begin
        r_nxt.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0)
        begin
          if ((r.st == emi_pkg::ST_LEAD) && r.mux)
          begin
            r_nxt.st = emi_pkg::ST_ALE_HI;
            r_nxt.cnt = {2'h0, latch_f};
          end
          else if (r.st == emi_pkg::ST_ALE_HI)
          begin
            r_nxt.st = emi_pkg::ST_ALE_LO;
            r_nxt.cnt = {2'h0, latch_f};
          end
          else if ((r.st != emi_pkg::ST_SETUP) && (setup_f != 2'h0))
          begin
            r_nxt.st = emi_pkg::ST_SETUP;
            r_nxt.cnt = {2'h0, setup_f} - 4'h1;
          end
          else
          begin
            r_nxt.st = emi_pkg::ST_STROBE;
            r_nxt.cnt = strobe_f;
          end
        end
      end
      emi_pkg::ST_STROBE, emi_pkg::ST_HOLD:
      begin
        r_nxt.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0)
        begin
          r_nxt.mark1 = (r.st == emi_pkg::ST_STROBE) && !r.write;
          if ((r.st == emi_pkg::ST_STROBE) && (hold_f != 2'h0))
          begin
            r_nxt.st = emi_pkg::ST_HOLD;
            r_nxt.cnt = {2'h0, hold_f} - 4'h1;
          end
          else
          begin
            r_nxt.st = emi_pkg::ST_TAIL;
            r_nxt.cnt = emi_pkg::TAIL_CYC - 4'h1;
          end
        end
      end
      emi_pkg::ST_TAIL:
      begin
        r_nxt.cnt = r.cnt - 4'h1;
        if (r.cnt == 4'h0)
        begin
          r_nxt.st = emi_pkg::ST_IDLE;
          r_nxt.busy = 1'b0;
          r_nxt.done = 1'b1;
        end
      end
      default:
      begin
        r_nxt.st = emi_pkg::ST_IDLE;
        r_nxt.busy = 1'b0;
      end
    endcase

    // pin drive follows the next state, so pins change with the state flops
    drive = (r_nxt.st != emi_pkg::ST_IDLE) && (r_nxt.st != emi_pkg::ST_ONCHIP) &&
            (r_nxt.st != emi_pkg::ST_TAIL);
    addr_phase = (r_nxt.st == emi_pkg::ST_LEAD) || (r_nxt.st == emi_pkg::ST_ALE_HI);
    r_nxt.ale = r_nxt.st == emi_pkg::ST_ALE_HI;
    r_nxt.rd_n = !((r_nxt.st == emi_pkg::ST_STROBE) && !r_nxt.write);
    r_nxt.wr_n = !((r_nxt.st == emi_pkg::ST_STROBE) && r_nxt.write);
    r_nxt.hi_oe_n = !(drive && r_nxt.hi_drv);
    r_nxt.lo_oe_n = !(drive && !r_nxt.mux);
    r_nxt.ad = (r_nxt.mux && addr_phase) ? r_nxt.ea[7:0] : r_nxt.wdata;
    r_nxt.ad_oe_n = !(drive && ((r_nxt.mux && addr_phase) || r_nxt.write));
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      r <= REGS_RST;
    end
    else
    begin
      r <= r_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign sfr_rdata_out    = r.sfr_rdata;
  assign move_busy_out    = r.busy;
  assign move_done_out    = r.done;
  assign move_rdata_out   = r.rdata;
  assign onchip_req_out   = r.on_req;
  assign onchip_we_out    = r.on_we;
  assign onchip_addr_out  = r.ea[9:0];
  assign onchip_wdata_out = r.wdata;
  assign ad_out           = r.ad;
  assign ad_oe_n_out      = r.ad_oe_n;
  assign addr_lo_out      = r.ea[7:0];
  assign addr_lo_oe_n_out = r.lo_oe_n;
  assign addr_hi_out      = r.ea[15:8];
  assign addr_hi_oe_n_out = r.hi_oe_n;
  assign ale_out          = r.ale;
  assign rd_n_out         = r.rd_n;
  assign wr_n_out         = r.wr_n;

  //////////////////////////////////////////////////////////////////////////////
  // checking helpers: access length and expected length
  logic [5:0] chk_len;
  logic       chk_off;
  logic [5:0] chk_expect;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      chk_len <= 6'h00;
      chk_off <= 1'b0;
    end
    else
    begin
      chk_len <= (r.st == emi_pkg::ST_IDLE) ? 6'h00 : chk_len + 6'h01;
      if (r.st == emi_pkg::ST_LEAD)
      begin
        chk_off <= 1'b1;
      end
      else if (r.st == emi_pkg::ST_ONCHIP)
      begin
        chk_off <= 1'b0;
      end
    end
  end

  assign chk_expect = {4'h0, setup_f} + {2'h0, strobe_f} + 6'h01 + {4'h0, hold_f} +
                      emi_pkg::FIXED_CYC +
                      (r.mux ? ({4'h0, latch_f} + 6'h01) << 1 : 6'h00);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  property p_idle_release;
    (r.st == emi_pkg::ST_IDLE) |-> ad_oe_n_out && addr_lo_oe_n_out && addr_hi_oe_n_out;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("pins driven while idle");

  property p_ale_addr;
    ale_out |-> r.mux && !ad_oe_n_out && (ad_out == r.ea[7:0]) && rd_n_out && wr_n_out;
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("latch phase without address");

  property p_ale_fall;
    $fell(ale_out) |-> ##[1:8] (!rd_n_out || !wr_n_out);
  endproperty
  a_ale_fall: assert property (p_ale_fall) else $error("no strobe after latch phase");

  property p_read_release;
    (!rd_n_out && r.mux) |-> ad_oe_n_out && !ale_out;
  endproperty
  a_read_release: assert property (p_read_release) else $error("shared pins driven in read");

  property p_nonmux;
    (!rd_n_out || !wr_n_out) && !r.mux |-> !addr_lo_oe_n_out && $stable(ale_out) && !ale_out;
  endproperty
  a_nonmux: assert property (p_nonmux) else $error("separate pins not used");

  property p_internal;
    (move_req_in && (r.st == emi_pkg::ST_IDLE) && (mode_f == emi_pkg::MODE_INTERNAL)) |=>
      onchip_req_out && (onchip_addr_out == $past(req_ea[9:0]));
  endproperty
  a_internal: assert property (p_internal) else $error("internal mode not on-chip");

  property p_upper_free;
    (move_req_in && (r.st == emi_pkg::ST_IDLE) && !move_wide_in && !req_onchip &&
     ((mode_f == emi_pkg::MODE_SPLIT) || (mode_f == emi_pkg::MODE_EXTERNAL))) |=>
      addr_hi_oe_n_out [*4];
  endproperty
  a_upper_free: assert property (p_upper_free) else $error("upper byte driven");

  property p_bank;
    (move_req_in && (r.st == emi_pkg::ST_IDLE) && !move_wide_in && !req_onchip &&
     (mode_f == emi_pkg::MODE_BANK)) |=>
      !addr_hi_oe_n_out && (addr_hi_out == $past(r.page));
  endproperty
  a_bank: assert property (p_bank) else $error("bank byte not driven");

  property p_len_plain;
    (move_done_out && chk_off && !r.mux) |-> (chk_len == chk_expect) && (chk_len >= 6'd5);
  endproperty
  a_len_plain: assert property (p_len_plain) else $error("off-chip access length wrong");

  property p_len_mux;
    (move_done_out && chk_off && r.mux) |-> (chk_len == chk_expect) && (chk_len >= 6'd7);
  endproperty
  a_len_mux: assert property (p_len_mux) else $error("multiplexed access length wrong");

endmodule : external_memory_interface

/* File: rtl/emi_pkg.sv */
// What this block does
// - Multiplexed mode shares eight pins between low address byte and data.
// - The block drives the address-latch strobe itself.
// - First multiplexed phase: strobe high, low address byte on shared pins.
// - Strobe falling starts phase two; shared pins then carry data.
// - Non-multiplexed mode uses separate data and address pins, no latch phase.
// - Mode 00 sends every move on-chip, address wrapping modulo 1k.
// - Byte move address is page:index; wide move uses the data pointer.
// - Modes 01 and 10 send addresses below 1k on-chip, others off-chip.
// - Mode 01 byte moves off-chip leave upper address pins undriven.
// - Split-mode wide moves decide by pointer and drive all sixteen bits.
// - Mode 10 byte moves drive upper byte from page register.
// - Mode 11 sends all off-chip; byte moves leave upper pins undriven.
// - Setup, hold, strobe and latch widths are programmable in clock cycles.
// - Off-chip access lasts setup plus strobe plus hold plus four cycles.
// - Multiplexed access adds at least two latch cycles; minimum seven.
// - Timing register resets to all ones.
// - Bits 7-6 give zero to three setup cycles.
// - Bits 5-2 give strobe width of field plus one cycles.
// - Bits 1-0 give zero to three hold cycles.
// - Mux bit set selects non-multiplexed timing for every off-chip mode.
// - Config bit 4 clear means multiplexed, set means separate pins.
// - Latch width field sets latch high and low widths to field plus one.
// - Pins are driven only during an off-chip move; inputs are released.
package emi_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] TIMING_ADDR = 8'hF7;
  localparam logic [7:0] CONFIG_ADDR = 8'hC7;
  localparam logic [7:0] PAGE_ADDR   = 8'hAA;

  // reset values
  localparam logic [7:0] TIMING_RST = 8'hFF;
  localparam logic [4:0] CONFIG_RST = 5'h03;
  localparam logic [7:0] PAGE_RST   = 8'h00;

  // timing register fields
  localparam int SETUP_LSB  = 6;
  localparam int STROBE_LSB = 2;
  localparam int HOLD_LSB   = 0;

  // configuration register fields
  localparam int MUX_BIT   = 4;
  localparam int MODE_LSB  = 2;
  localparam int LATCH_LSB = 0;

  // memory modes
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT    = 2'h1;
  localparam logic [1:0] MODE_BANK     = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // on-chip ram size boundary
  localparam logic [15:0] ONCHIP_SIZE = 16'h0400;

  // fixed cycles of an off-chip access: one lead plus tail
  localparam logic [3:0] TAIL_CYC  = 4'h3;
  localparam logic [5:0] FIXED_CYC = 6'h04;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ONCHIP = 4'b0001,
    ST_LEAD   = 4'b0010,
    ST_ALE_HI = 4'b0011,
    ST_ALE_LO = 4'b0100,
    ST_SETUP  = 4'b0101,
    ST_STROBE = 4'b0110,
    ST_HOLD   = 4'b0111,
    ST_TAIL   = 4'b1000
  } emi_state_t;

endpackage : emi_pkg

/* File: verif/ext_sram_model.sv */
`timescale 1ns/1ps
module ext_sram_model (
  // pins driven by the interface
  input  wire logic [7:0] ad_in,
  input  wire logic       ad_oe_n_in,
  input  wire logic [7:0] addr_lo_in,
  input  wire logic       addr_lo_oe_n_in,
  input  wire logic [7:0] addr_hi_in,
  input  wire logic       addr_hi_oe_n_in,
  input  wire logic       ale_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  // resolved level of the shared pins
  output logic      [7:0] ad_pins_out
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  latch_q;
  logic [15:0] addr;
  ////////////////////////////////////////////////////////////////////////
  // transparent while the strobe is high, frozen once it falls
  // settles after the pins, so a falling strobe never catches the next byte
  always @(ale_in or ad_in)
  begin
    #1;
    if (ale_in)
      latch_q <= ad_in;
  end
  // undriven upper pins show the parked port latches, all ones
  assign addr = {addr_hi_oe_n_in ? 8'hFF : addr_hi_in,
                 addr_lo_oe_n_in ? latch_q : addr_lo_in};
  ////////////////////////////////////////////////////////////////////////
  // data is valid while the write strobe is low
  always @(negedge wr_n_in)
    #1 mem[addr] <= ad_in;
  // read data stands while the read strobe is low, the driven byte while the interface drives, pull-up level otherwise
  assign ad_pins_out = !ad_oe_n_in ? ad_in : (!rd_n_in ? mem[addr] : 8'hFF);
endmodule : ext_sram_model

/* File: verif/external_memory_interface_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module external_memory_interface_tb;
  typedef struct {logic [7:0] cfg, tc; logic wd; logic [15:0] a, loc; logic on;} row_t;
  logic        clk = 1'b0, arst_n = 1'b0, swr = 1'b0, srd = 1'b0;
  logic        mreq = 1'b0, wide = 1'b0, wr = 1'b0, mux_now = 1'b1;
  logic [7:0]  sa = 8'h00, swd = 8'h00, mwd = 8'h00, ord = 8'h00, lo_exp = 8'h00;
  logic [15:0] dp = 16'h0000;
  logic [7:0]  srdata, mrd, owd, pins, ad, alo, ahi;
  logic [9:0]  oaddr;
  logic        busy, done, oreq, owe, adoe, aloe, ahoe, ale, rdn, wrn;
  logic [7:0]  ram [0:1023];
  int          n_fail = 0, cmp_count = 0, cyc = 0, n, k;
  row_t rows [8] = '{
    '{8'h00, 8'h00, 1'b1, 16'h1401, 16'h0001, 1'b1},
    '{8'h04, 8'h00, 1'b0, 16'h1234, 16'hFF34, 1'b0},
    '{8'h14, 8'h00, 1'b1, 16'h03FF, 16'h03FF, 1'b1},
    '{8'h18, 8'h00, 1'b0, 16'h5678, 16'h5678, 1'b0},
    '{8'h09, 8'h47, 1'b1, 16'h0400, 16'h0400, 1'b0},
    '{8'h1C, 8'hFF, 1'b0, 16'h0110, 16'hFF10, 1'b0},
    '{8'h0F, 8'h3C, 1'b1, 16'h0002, 16'h0002, 1'b0},
    '{8'h00, 8'h00, 1'b0, 16'h0722, 16'h0322, 1'b1}};
  ////////////////////////////////////////////////////////////////////////
  external_memory_interface DUT (
    .clk_sys_in(clk), .arst_n_in(arst_n), .sfr_addr_in(sa), .sfr_wr_in(swr),
    .sfr_rd_in(srd), .sfr_wdata_in(swd), .sfr_rdata_out(srdata), .move_req_in(mreq),
    .move_wide_in(wide), .move_write_in(wr), .index_reg_in(dp[7:0]),
    .data_pointer_in(dp), .move_wdata_in(mwd), .move_busy_out(busy),
    .move_done_out(done), .move_rdata_out(mrd), .onchip_req_out(oreq),
    .onchip_we_out(owe), .onchip_addr_out(oaddr), .onchip_wdata_out(owd),
    .onchip_rdata_in(ord), .ad_pins_in(pins), .ad_out(ad), .ad_oe_n_out(adoe),
    .addr_lo_out(alo), .addr_lo_oe_n_out(aloe), .addr_hi_out(ahi),
    .addr_hi_oe_n_out(ahoe), .ale_out(ale), .rd_n_out(rdn), .wr_n_out(wrn));
  ext_sram_model mem_model (
    .ad_in(ad), .ad_oe_n_in(adoe), .addr_lo_in(alo), .addr_lo_oe_n_in(aloe),
    .addr_hi_in(ahi), .addr_hi_oe_n_in(ahoe), .ale_in(ale), .rd_n_in(rdn),
    .wr_n_in(wrn), .ad_pins_out(pins));
  ////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  // synchronous on-chip ram, one cycle of read latency
  always @(posedge clk)
  begin
    if (oreq)
    begin
      if (owe)
        ram[oaddr] <= owd;
      ord <= ram[oaddr];
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      results();
    end
  end
  // pin watch during every cycle after reset
  always @(negedge clk)
  begin
    if (arst_n && ale)
      `CHK({adoe, ad}, {1'b0, lo_exp})
    if (arst_n && !mux_now)
      `CHK(ale, 1'b0)
    if (arst_n && !rdn)
      `CHK(adoe, 1'b1)
    if (arst_n && !wrn)
      `CHK({adoe, ad}, {1'b0, mwd})
  end
  ////////////////////////////////////////////////////////////////////////
  task results;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    sa = a;
    swd = d;
    swr = w;
    srd = !w;
    @(negedge clk);
    swr = 1'b0;
    srd = 1'b0;
    // one idle edge, so the next call never raises a strobe in the same step
    @(negedge clk);
  endtask : sfr
  task move(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d,
            input int ecyc);
    wide = wd;
    wr = w;
    dp = a;
    mwd = d;
    lo_exp = a[7:0];
    mreq = 1'b1;
    @(negedge clk);
    mreq = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, ecyc)
  endtask : move
  task rst_chk;
    `CHK({adoe, aloe, ahoe, ale, rdn, wrn, busy}, 7'b1110110)
    sfr(1'b0, emi_pkg::TIMING_ADDR, 8'h00);
    `CHK(srdata, 8'hFF)
    sfr(1'b0, emi_pkg::CONFIG_ADDR, 8'h00);
    `CHK(srdata, 8'h03)
  endtask : rst_chk
  // done edge count: on-chip fixed, off-chip is the busy span plus one
  function automatic int cyc_of(row_t r);
    if (r.on)
      return 3;
    return r.tc[7:6] + r.tc[5:2] + 1 + r.tc[1:0] + 4 + 1 +
           (r.cfg[4] ? 0 : 2 * (r.cfg[1:0] + 1));
  endfunction : cyc_of
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    rst_chk();
    for (int i = 0; i < 8; i++)
    begin
      sfr(1'b1, emi_pkg::CONFIG_ADDR, rows[i].cfg);
      sfr(1'b1, emi_pkg::TIMING_ADDR, rows[i].tc);
      sfr(1'b1, emi_pkg::PAGE_ADDR, rows[i].a[15:8]);
      mux_now = !rows[i].cfg[4];
      move(1'b1, rows[i].wd, rows[i].a, 8'hA0 + i[7:0], cyc_of(rows[i]));
      `CHK(rows[i].on ? ram[rows[i].loc[9:0]] : mem_model.mem[rows[i].loc], 8'hA0 + i[7:0])
      move(1'b0, rows[i].wd, rows[i].a, 8'h00, cyc_of(rows[i]));
      `CHK(mrd, 8'hA0 + i[7:0])
    end
    `CHK({adoe, aloe, ahoe, ale, rdn, wrn}, 6'b111011)
    // unused config bits read zero, unmapped address reads zero
    sfr(1'b1, emi_pkg::CONFIG_ADDR, 8'hFF);
    sfr(1'b0, emi_pkg::CONFIG_ADDR, 8'h00);
    `CHK(srdata, 8'h1F)
    sfr(1'b0, 8'h55, 8'h00);
    `CHK(srdata, 8'h00)
    // a request while busy is dropped: one done pulse only
    sfr(1'b1, emi_pkg::CONFIG_ADDR, 8'h1C);
    sfr(1'b1, emi_pkg::TIMING_ADDR, 8'h00);
    mux_now = 1'b0;
    wide = 1'b1;
    wr = 1'b0;
    dp = 16'h5678;
    mreq = 1'b1;
    @(negedge clk);
    mreq = 1'b0;
    @(negedge clk);
    mreq = 1'b1;
    @(negedge clk);
    mreq = 1'b0;
    k = 0;
    repeat (12)
    begin
      @(negedge clk);
      k += done;
    end
    `CHK(k, 1)
    `CHK(mrd, 8'hA3)
    // reset again in mid-run
    arst_n = 1'b0;
    mux_now = 1'b1;
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    rst_chk();
    results();
  end
endmodule : external_memory_interface_tb
